// ---- design/stb_regs.svh ----
// Overview of operation
// - Every 128-bit block in gives one 128-bit block out, enciphering or deciphering.
// - The key is 128 or 256 bits long, picked per data unit by key_size_select.
// - key_size_select low gives 10 rounds and high gives 14 rounds.
// - The incoming block is first XORed with the tweak and round key 0 (round key nr when deciphering) and kept as the working state.
// - A normal round does ByteSub, ShiftRow, MixColumn, AddRoundKey and stores the state.
// - The final round leaves out MixColumn and only then is the result presented.
// - When enciphering, each round key is derived on the fly and registered ahead of the cycle that uses it.
// - For deciphering the whole schedule is first expanded into memory and read backwards.
// - Each accepted block yields exactly one output block, with no padding or expansion.
// - Data units are independent and no chaining state survives from one unit to the next.
// - The datapath is 128 bits wide at either key size.
// - All state moves on the one system clock.
`ifndef STB_REGS_SVH
`define STB_REGS_SVH

`define STB_NR_SHORT  4'hA
`define STB_NR_LONG   4'hE
`define STB_KEY_DEPTH 15
`define STB_RCON_INIT 8'h01
`define STB_GF_POLY   8'h1B
`define STB_XTS_POLY  8'h87
`define STB_AFF_FWD   8'h63
`define STB_AFF_INV   8'h05

`endif

// ---- design/stb_pkg.sv ----
`default_nettype none
package stb_pkg;

    // Per data unit setup, taken once at the unit's start
    typedef struct packed {
        logic         decrypt;
        logic         key_size_select;
        logic [255:0] key_data;
        logic [255:0] key_tweak;
        logic [127:0] tweak;
    } stb_unit_s;

    // One data block with its end-of-unit mark
    typedef struct packed {
        logic         last;
        logic [127:0] data;
    } stb_blk_s;

    typedef enum logic [2:0] {
        stb_idle,
        stb_twk,
        stb_exp,
        stb_waitb,
        stb_rnd
    } stb_state_e;

endpackage
`default_nettype wire

// ---- design/stb_key_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "stb_regs.svh"

module stb_key_mem (
    // Clock
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Write port
    input  wire logic         wr_en,
    input  wire logic [3:0]   wr_addr,
    input  wire logic [127:0] wr_data,
    // Registered read port
    input  wire logic [3:0]   rd_addr,
    output logic      [127:0] rd_data
);

    logic [127:0] mem [0:`STB_KEY_DEPTH-1];

    // Write-first so a key written now is readable next cycle
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data <= 128'h0;
        end else if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule
`default_nettype wire

// ---- design/stb_out_buf.sv ----
`timescale 1ns/10ps
`default_nettype none

module stb_out_buf (
    // Clock
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Fill side
    input  wire logic              in_valid,
    input  wire stb_pkg::stb_blk_s in_blk,
    output logic                   in_ready,
    // Drain side
    output logic                   out_valid,
    output stb_pkg::stb_blk_s      out_blk,
    input  wire logic              out_ready
);

    logic              v1;
    stb_pkg::stb_blk_s d1;
    wire               pop  = out_valid & out_ready;
    wire               push = in_valid & in_ready;

    // Second slot only fills while the head is stalled
    assign in_ready = ~v1;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            v1        <= 1'b0;
            out_blk   <= '0;
            d1        <= '0;
        end else if (pop && v1) begin
            out_blk <= d1;
            v1      <= 1'b0;
        end else if (pop || !out_valid) begin
            out_valid <= push;
            if (push) begin
                out_blk <= in_blk;
            end
        end else if (push) begin
            v1 <= 1'b1;
            d1 <= in_blk;
        end
    end

endmodule
`default_nettype wire

// ---- design/stb_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "stb_regs.svh"

module stb_core (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Data unit setup
    input  wire logic               unit_valid,
    input  wire stb_pkg::stb_unit_s unit_cfg,
    output logic                    unit_ready,
    // Blocks in
    input  wire logic               blk_in_valid,
    input  wire stb_pkg::stb_blk_s  blk_in,
    output logic                    blk_in_ready,
    // Blocks out
    output logic                    blk_out_valid,
    output stb_pkg::stb_blk_s       blk_out,
    input  wire logic               blk_out_ready
);

    // Field arithmetic
    function automatic logic [7:0] xt(input logic [7:0] b);
        return {b[6:0], 1'b0} ^ (b[7] ? `STB_GF_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = xt(x);
        end
        return p;
    endfunction

    // Inverse as b^254; zero maps to zero by itself
    function automatic logic [7:0] ginv(input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] r;
        p = b;
        r = 8'h01;
        for (int i = 0; i < 7; i++) begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        return r;
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] b, input logic inv);
        logic [7:0] x;
        logic [7:0] y;
        x = ginv(b);
        y = {b[6:0], b[7]} ^ {b[4:0], b[7:5]} ^ {b[1:0], b[7:2]} ^ `STB_AFF_INV;
        if (inv) return ginv(y);
        return x ^ {x[6:0], x[7]} ^ {x[5:0], x[7:6]} ^ {x[4:0], x[7:5]}
                 ^ {x[3:0], x[7:4]} ^ `STB_AFF_FWD;
    endfunction

    // Byte substitution fused with row shift; byte 4c+r is row r of column c
    function automatic logic [127:0] subshift(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        int           src;
        o = '0;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                src = inv ? 4 * ((c + 4 - r) % 4) + r : 4 * ((c + r) % 4) + r;
                o[127 - 8 * (4 * c + r) -: 8] = sbox(s[127 - 8 * src -: 8], inv);
            end
        end
        return o;
    endfunction

    function automatic logic [127:0] mixcol(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        logic [31:0]  k;
        logic [7:0]   acc;
        o = '0;
        k = inv ? 32'h0E0B0D09 : 32'h02030101;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                acc = 8'h00;
                for (int j = 0; j < 4; j++) begin
                    acc = acc ^ gmul(s[127 - 8 * (4 * c + j) -: 8],
                                     k[31 - 8 * ((j + 4 - r) % 4) -: 8]);
                end
                o[127 - 8 * (4 * c + r) -: 8] = acc;
            end
        end
        return o;
    endfunction

    // Next round key from the previous one and the newest word
    function automatic logic [127:0] ks_step(input logic [127:0] prev, input logic [31:0] lw,
                                             input logic rot, input logic [7:0] rc);
        logic [31:0]  w;
        logic [31:0]  t;
        logic [127:0] o;
        w = rot ? {lw[23:0], lw[31:24]} : lw;
        t = {sbox(w[31:24], 1'b0), sbox(w[23:16], 1'b0), sbox(w[15:8], 1'b0),
             sbox(w[7:0], 1'b0)} ^ {(rot ? rc : 8'h00), 24'h0};
        o[127:96] = prev[127:96] ^ t;
        o[95:64]  = prev[95:64] ^ o[127:96];
        o[63:32]  = prev[63:32] ^ o[95:64];
        o[31:0]   = prev[31:0] ^ o[63:32];
        return o;
    endfunction

    // Tweak times alpha, bytes taken least significant first
    function automatic logic [127:0] mul_alpha(input logic [127:0] t);
        logic [127:0] o;
        logic         cy;
        cy = 1'b0;
        for (int i = 0; i < 16; i++) begin
            o[127 - 8 * i -: 8] = {t[126 - 8 * i -: 7], cy};
            cy = t[127 - 8 * i];
        end
        o[127:120] = o[127:120] ^ (cy ? `STB_XTS_POLY : 8'h00);
        return o;
    endfunction

    // State
    stb_pkg::stb_state_e state;
    stb_pkg::stb_state_e next_state;
    stb_pkg::stb_unit_s  cfg;
    stb_pkg::stb_unit_s  next_cfg;
    logic [3:0]          kidx;
    logic [3:0]          next_kidx;
    logic [127:0]        st;
    logic [127:0]        next_st;
    logic [127:0]        twk;
    logic [127:0]        next_twk;
    logic [127:0]        ka;
    logic [127:0]        kb;
    logic [7:0]          rcon;
    logic                phase;
    logic                last_blk;
    logic                next_last_blk;
    logic                adv;
    logic                mem_we;
    logic                push;
    logic [127:0]        mem_rd;
    logic                buf_ready;

    // Decode of mode, round count and handshakes
    wire        in_idle   = state == stb_pkg::stb_idle;
    wire        ksz       = in_idle ? unit_cfg.key_size_select : cfg.key_size_select;
    wire        mode128   = ~ksz;
    wire [3:0]  nr        = cfg.key_size_select ? `STB_NR_LONG : `STB_NR_SHORT;
    wire        dec_data  = cfg.decrypt && (state == stb_pkg::stb_waitb
                                           || state == stb_pkg::stb_rnd);
    wire        last_k    = dec_data ? (kidx == 4'h0) : (kidx == nr);
    wire        unit_take = in_idle && unit_valid && unit_ready;
    wire        blk_take  = state == stb_pkg::stb_waitb && blk_in_valid && blk_in_ready;
    wire        fin_blk   = state == stb_pkg::stb_rnd && last_k;
    wire        stall     = fin_blk && !buf_ready;

    // On-the-fly expander: round key kidx is ea, restarted when kidx is zero
    wire         fresh    = kidx == 4'h0;
    wire [255:0] key_src  = in_idle ? unit_cfg.key_tweak : cfg.key_data;
    wire [127:0] ea       = fresh ? key_src[255:128] : ka;
    wire [127:0] eb       = fresh ? key_src[127:0] : kb;
    wire [7:0]   rc_e     = fresh ? `STB_RCON_INIT : rcon;
    wire         ph_e     = fresh ? 1'b0 : phase;
    wire         rot      = mode128 | ~ph_e;
    wire [127:0] kc       = ks_step(ea, mode128 ? ea[31:0] : eb[31:0], rot, rc_e);

    // Round datapaths, one round per cycle on a 128-bit state
    wire [127:0] enc_sub  = subshift(st, 1'b0);
    wire [127:0] rnd_enc  = (kidx == nr ? enc_sub : mixcol(enc_sub, 1'b0)) ^ ea;
    wire [127:0] dec_add  = subshift(st, 1'b1) ^ mem_rd;
    wire [127:0] rnd_dec  = kidx == 4'h0 ? dec_add : mixcol(dec_add, 1'b1);
    wire [127:0] rnd_out  = dec_data ? rnd_dec : rnd_enc;
    wire [127:0] rk_first = cfg.decrypt ? mem_rd : ea;
    stb_pkg::stb_blk_s res;

    assign res      = {last_blk, rnd_out ^ twk};
    assign push     = fin_blk && buf_ready;

    // Sequencing of tweak, key expansion and block rounds
    always_comb begin
        next_state    = state;
        next_cfg      = cfg;
        next_kidx     = kidx;
        next_st       = st;
        next_twk      = twk;
        next_last_blk = last_blk;
        adv           = 1'b0;
        mem_we        = 1'b0;
        case (state)
            stb_pkg::stb_idle: begin
                if (unit_take) begin
                    next_cfg   = unit_cfg;
                    next_st    = unit_cfg.tweak ^ ea;
                    next_kidx  = 4'h1;
                    adv        = 1'b1;
                    next_state = stb_pkg::stb_twk;
                end
            end
            stb_pkg::stb_twk: begin
                next_st   = rnd_enc;
                next_kidx = kidx + 4'h1;
                adv       = 1'b1;
                if (last_k) begin
                    next_twk   = rnd_enc;
                    next_kidx  = 4'h0;
                    next_state = cfg.decrypt ? stb_pkg::stb_exp : stb_pkg::stb_waitb;
                end
            end
            stb_pkg::stb_exp: begin
                mem_we    = 1'b1;
                adv       = 1'b1;
                next_kidx = kidx + 4'h1;
                if (last_k) begin
                    next_kidx  = nr;
                    next_state = stb_pkg::stb_waitb;
                end
            end
            stb_pkg::stb_waitb: begin
                if (blk_take) begin
                    next_st       = blk_in.data ^ twk ^ rk_first;
                    next_last_blk = blk_in.last;
                    next_kidx     = cfg.decrypt ? nr - 4'h1 : 4'h1;
                    adv           = ~cfg.decrypt;
                    next_state    = stb_pkg::stb_rnd;
                end
            end
            stb_pkg::stb_rnd: begin
                if (!stall) begin
                    next_st   = rnd_out;
                    next_kidx = dec_data ? kidx - 4'h1 : kidx + 4'h1;
                    adv       = 1'b1;
                    if (last_k) begin
                        next_twk   = mul_alpha(twk);
                        // Unit end parks at key 0 so the next tweak key starts fresh
                        next_kidx  = (cfg.decrypt && !last_blk) ? nr : 4'h0;
                        next_state = last_blk ? stb_pkg::stb_idle : stb_pkg::stb_waitb;
                    end
                end
            end
            default: begin
                next_state = stb_pkg::stb_idle;
            end
        endcase
    end

    // Single clock for every register, datapath and control alike
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state        <= stb_pkg::stb_idle;
            cfg          <= '0;
            kidx         <= 4'h0;
            st           <= 128'h0;
            twk          <= 128'h0;
            last_blk     <= 1'b0;
            unit_ready   <= 1'b0;
            blk_in_ready <= 1'b0;
        end else begin
            state        <= next_state;
            cfg          <= next_cfg;
            kidx         <= next_kidx;
            st           <= next_st;
            twk          <= next_twk;
            last_blk     <= next_last_blk;
            unit_ready   <= next_state == stb_pkg::stb_idle;
            blk_in_ready <= next_state == stb_pkg::stb_waitb;
        end
    end

    // Expander registers hold key kidx and, with a 256-bit key, key kidx+1
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ka    <= 128'h0;
            kb    <= 128'h0;
            rcon  <= 8'h00;
            phase <= 1'b0;
        end else if (adv) begin
            ka    <= mode128 ? kc : eb;
            kb    <= kc;
            rcon  <= rot ? xt(rc_e) : rc_e;
            phase <= ~ph_e;
        end
    end

    // Round keys for deciphering, written forward and read backward
    stb_key_mem u_key_mem (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (mem_we),
        .wr_addr (kidx),
        .wr_data (ea),
        .rd_addr (next_kidx),
        .rd_data (mem_rd)
    );

    // Two-entry buffer so a stalled receiver loses no block
    stb_out_buf u_out_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (push),
        .in_blk    (res),
        .in_ready  (buf_ready),
        .out_valid (blk_out_valid),
        .out_blk   (blk_out),
        .out_ready (blk_out_ready)
    );

endmodule
`default_nettype wire

// ---- verification/stb_core_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

module stb_core_asserts (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Unit setup
    input  wire logic               unit_valid,
    input  wire stb_pkg::stb_unit_s unit_cfg,
    input  wire logic               unit_ready,
    // Blocks in and out
    input  wire logic               blk_in_valid,
    input  wire stb_pkg::stb_blk_s  blk_in,
    input  wire logic               blk_in_ready,
    input  wire logic               blk_out_valid,
    input  wire stb_pkg::stb_blk_s  blk_out,
    input  wire logic               blk_out_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [5:0] u_cnt;
    logic [5:0] b_cnt;
    logic [4:0] nr;
    logic       u_dec;
    logic [2:0] pend;
    wire        unit_take = unit_valid && unit_ready;
    wire        blk_take  = blk_in_valid && blk_in_ready;
    wire        out_take  = blk_out_valid && blk_out_ready;

    // Cycles since the last take; saturating so a long stall never wraps
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            u_cnt <= 6'h00;
            b_cnt <= 6'h00;
            nr    <= 5'h0A;
            u_dec <= 1'b0;
            pend  <= 3'h0;
        end else begin
            if (unit_take) begin
                u_cnt <= 6'h01;
                u_dec <= unit_cfg.decrypt;
                nr    <= unit_cfg.key_size_select ? 5'h0E : 5'h0A;
            end else if (blk_in_ready)
                u_cnt <= 6'h00;
            else if (u_cnt != 6'h00 && u_cnt != 6'h3F)
                u_cnt <= u_cnt + 6'h01;
            if (blk_take)
                b_cnt <= 6'h01;
            else if (b_cnt != 6'h3F)
                b_cnt <= b_cnt + 6'h01;
            pend <= pend + 3'(blk_take) - 3'(out_take);
        end
    end

    property p_unit_drop; unit_take |=> !unit_ready; endproperty
    a_unit_drop: assert property (p_unit_drop) else $error("setup ready held");
    property p_in_drop; blk_take |=> !blk_in_ready; endproperty
    a_in_drop: assert property (p_in_drop) else $error("input ready held");
    property p_out_hold;
        blk_out_valid && !blk_out_ready |=> blk_out_valid && $stable(blk_out);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output lost in stall");
    property p_unit_lat;
        $rose(blk_in_ready) && u_cnt != 6'h00 |-> u_cnt == (u_dec ? 2 * nr + 2 : nr + 1);
    endproperty
    a_unit_lat: assert property (p_unit_lat) else $error("setup latency");
    property p_blk_lat;
        $rose(blk_out_valid) |-> b_cnt == nr + 1 && (blk_in_ready || unit_ready);
    endproperty
    a_blk_lat: assert property (p_blk_lat) else $error("block latency");
    property p_no_extra; blk_out_valid |-> pend != 3'h0; endproperty
    a_no_extra: assert property (p_no_extra) else $error("output without input");
    property p_pend_max; pend <= 3'h3; endproperty
    a_pend_max: assert property (p_pend_max) else $error("too many in flight");
    property p_last_busy; blk_take && blk_in.last |=> !unit_ready [*8]; endproperty
    a_last_busy: assert property (p_last_busy) else $error("unit ended early");
    property p_excl; !(unit_ready && blk_in_ready); endproperty
    a_excl: assert property (p_excl) else $error("two units open");

    // Main scenarios
    c_dec: cover property (unit_take && unit_cfg.decrypt);
    c_long: cover property (unit_take && unit_cfg.key_size_select);
    c_stall: cover property (blk_out_valid && !blk_out_ready);
endmodule

bind stb_core stb_core_asserts stb_core_asserts_i (
    .clk_sys(clk_sys), .rst(rst), .unit_valid(unit_valid), .unit_cfg(unit_cfg),
    .unit_ready(unit_ready), .blk_in_valid(blk_in_valid), .blk_in(blk_in),
    .blk_in_ready(blk_in_ready), .blk_out_valid(blk_out_valid), .blk_out(blk_out),
    .blk_out_ready(blk_out_ready)
);

`default_nettype wire

// ---- verification/stb_host_sink.sv ----
`timescale 1ns/10ps
`default_nettype none

module stb_host_sink (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Pace control
    input  wire logic              slow,
    // Blocks from the core
    input  wire logic              blk_out_valid,
    input  wire stb_pkg::stb_blk_s blk_out,
    output logic                   blk_out_ready
);
    logic [4:0]   pace;
    logic [127:0] got [$];
    logic         lst [$];

    // Slow mode opens one cycle in 32 so the two-entry buffer fills
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pace          <= 5'h00;
            blk_out_ready <= 1'b0;
        end else begin
            pace          <= pace + 5'h01;
            blk_out_ready <= !slow || pace == 5'h1F;
        end
    end

    // A block counts only at an edge with both sides high
    always @(posedge clk_sys) begin
        if (!rst && blk_out_valid && blk_out_ready) begin
            got.push_back(blk_out.data);
            lst.push_back(blk_out.last);
        end
    end
endmodule

`default_nettype wire

// ---- verification/sector_tweak_block_cipher_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t ns: %s", $time, m); end end

module sector_tweak_block_cipher_test;
    localparam logic [255:0] kd = {16{16'h1F2E}};
    localparam logic [255:0] kt = {16{16'h7B4D}};
    localparam logic [127:0] tw = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
    localparam logic [127:0] kat0 = 128'h917CF69EBD68B2EC9B9FE9A3EADDA692;
    localparam logic [127:0] kat1 = 128'hCD43D2F59598ED858C02C2652FBF922E;

    logic               clk_sys;
    logic               rst = 1'b1;
    logic               unit_valid = 1'b0;
    stb_pkg::stb_unit_s unit_cfg = '0;
    logic               unit_ready;
    logic               blk_in_valid = 1'b0;
    stb_pkg::stb_blk_s  blk_in = '0;
    logic               blk_in_ready;
    logic               blk_out_valid;
    stb_pkg::stb_blk_s  blk_out;
    logic               blk_out_ready;
    logic               slow = 1'b0;
    int                 fails = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;
    logic [127:0]       src [3];
    logic [127:0]       ref1 [3];
    logic [127:0]       pt [3] = '{128'h0, {8{16'hFFFF}}, 128'h00112233445566778899AABBCCDDEEFF};

    stb_core stb_core_i (
        .clk_sys(clk_sys), .rst(rst), .unit_valid(unit_valid), .unit_cfg(unit_cfg),
        .unit_ready(unit_ready), .blk_in_valid(blk_in_valid), .blk_in(blk_in),
        .blk_in_ready(blk_in_ready), .blk_out_valid(blk_out_valid), .blk_out(blk_out),
        .blk_out_ready(blk_out_ready)
    );

    stb_host_sink stb_host_sink_i (
        .clk_sys(clk_sys), .rst(rst), .slow(slow), .blk_out_valid(blk_out_valid),
        .blk_out(blk_out), .blk_out_ready(blk_out_ready)
    );

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One unit from src; valid is held across blocks so it never toggles in one step
    task automatic run_unit(input logic dec, input logic ks, input logic [255:0] kdat,
                            input logic [255:0] ktwk, input logic [127:0] twk, input int n);
        int w;
        stb_host_sink_i.got.delete();
        stb_host_sink_i.lst.delete();
        unit_valid <= 1'b1;
        unit_cfg   <= '{dec, ks, kdat, ktwk, twk};
        w = 0;
        do begin @(posedge clk_sys); w++; end while (!unit_ready && w < 100);
        unit_valid   <= 1'b0;
        blk_in_valid <= 1'b1;
        blk_in       <= '{n == 1, src[0]};
        for (int i = 0; i < n; i++) begin
            w = 0;
            do begin @(posedge clk_sys); w++; end while (!blk_in_ready && w < 400);
            if (i < n - 1)
                blk_in <= '{i == n - 2, src[i + 1]};
            else
                blk_in_valid <= 1'b0;
        end
        w = 0;
        while (stb_host_sink_i.got.size() < n && w < 400) begin
            @(posedge clk_sys);
            w++;
        end
        `CHECK(stb_host_sink_i.got.size(), n, "block count")
        `CHECK(stb_host_sink_i.lst[n - 1], 1'b1, "last flag")
    endtask

    // Known answer with zero keys and tweak; the second block needs the tweak step
    task automatic test_vector;
        src[0] = '0;
        src[1] = '0;
        run_unit(1'b0, 1'b0, '0, '0, '0, 2);
        `CHECK(stb_host_sink_i.got[0], kat0, "blk0")
        `CHECK(stb_host_sink_i.got[1], kat1, "blk1")
        $display("test_vector done");
    endtask

    // Encipher then decipher with the same keys must give the plain blocks back
    task automatic test_round(input logic ks);
        src = pt;
        run_unit(1'b0, ks, kd, kt, tw, 3);
        for (int i = 0; i < 3; i++)
            src[i] = stb_host_sink_i.got[i];
        if (ks)
            ref1 = src;
        `CHECK(src[2] === pt[2], 1'b0, "cipher equals plain")
        run_unit(1'b1, ks, kd, kt, tw, 3);
        for (int i = 0; i < 3; i++)
            `CHECK(stb_host_sink_i.got[i], pt[i], "round trip")
        $display("test_round %0d done", ks);
    endtask

    // Slow receiver fills the buffer; repeat unit must match the earlier one
    task automatic test_stall;
        src = pt;
        slow <= 1'b1;
        run_unit(1'b0, 1'b1, kd, kt, tw, 3);
        slow <= 1'b0;
        for (int i = 0; i < 3; i++)
            `CHECK(stb_host_sink_i.got[i], ref1[i], "stalled unit")
        $display("test_stall done");
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        test_vector();
        test_round(1'b0);
        test_round(1'b1);
        test_stall();
        stop_test();
    end
endmodule

`default_nettype wire
